// *** core/sgr_core.sv ***
// command decode, bank state, refresh and graphic write core
`timescale 1ns/10ps
module sgr_core
    import sgr_pkg::*;
#(
    parameter int SR_INTERVAL = SR_INT_CYC
)
(
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             srst_in,
    // command pins
    input  wire logic             cke_in,
    input  wire logic             sel_n_in,
    input  wire logic             row_n_in,
    input  wire logic             col_n_in,
    input  wire logic             wr_n_in,
    input  wire logic             special_function_select_in,
    input  wire logic [AW-1:0]    addr_in,
    input  wire logic [MASKW-1:0] byte_mask_in,
    input  wire logic [DW-1:0]    dq_in,
    // array write port
    output logic                  wr_en_out,
    output logic                  wr_blk_out,
    output logic                  wr_bank_out,
    output logic [ROWW-1:0]       wr_row_out,
    output logic [COLW-1:0]       wr_col_out,
    output logic [DW-1:0]         wr_data_out,
    output logic [DW-1:0]         wr_bitsel_out,
    output logic [BLK_COLS*MASKW-1:0] wr_colsel_out,
    input  wire logic             wr_ready_in,
    // refresh port
    output logic                  ref_out,
    output logic [ROWW:0]         ref_row_out,
    // status
    output logic [1:0]            bank_active_out,
    output logic                  self_ref_out,
    output logic                  busy_out,
    output logic                  wq_stall_out,
    output logic [DW-1:0]         color_out,
    output logic [DW-1:0]         mask_out
);
    localparam int WQW = 1 + 1 + ROWW + COLW + DW + DW + BLK_COLS*MASKW;

    sgr_cmd_t          cmd;
    logic              clk_en_r;
    sgr_bank_t         bst_r [2];
    logic [ROWW-1:0]   row_r [2];
    logic [1:0]        wpb_r;
    logic [1:0]        ap_r;
    logic [7:0]        tcnt_r [2];
    logic [7:0]        busy_r;
    logic              sref_r;
    logic [15:0]       sr_tmr_r;
    logic [ROWW:0]     ref_row_r;
    logic              ref_r;
    logic [DW-1:0]     color_r;
    logic [DW-1:0]     mask_r;
    logic [DW-1:0]     bitsel;
    logic [BLK_COLS*MASKW-1:0] colsel;
    logic              bk;
    logic              wq_valid;
    logic              wq_ready;
    logic [WQW-1:0]    wq_data;
    logic              oq_valid;
    logic [WQW-1:0]    oq_data;
    logic              wr_en_r;
    logic [WQW-1:0]    wr_pack_r;
    logic              idle_all;

    assign bk       = addr_in[BANK_BIT];
    assign idle_all = (bst_r[0] == SGR_IDLE) && (bst_r[1] == SGR_IDLE);

    // command decode, gated by the delayed clock gate
    always_comb
    begin
        cmd = SGR_NOP;
        if (clk_en_r && !sref_r && !sel_n_in && busy_r == '0)
        begin
            unique case ({row_n_in, col_n_in, wr_n_in})
                3'b011: cmd = SGR_ACT;
                3'b101: cmd = SGR_RD;
                3'b100: cmd = SGR_WR;
                3'b010: cmd = addr_in[AP_BIT] ? SGR_PALL : SGR_PRE;
                3'b001: cmd = cke_in ? SGR_AREF : SGR_SREF;
                3'b000: cmd = special_function_select_in ? SGR_SLOAD
                                                         : SGR_MODE;
                default: cmd = SGR_NOP;
            endcase
        end
    end

    // internal clock suspend follows the gate one clock later
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            clk_en_r <= 1'b1;
        end
        else
        begin
            clk_en_r <= cke_in;
        end
    end

    // bank state per bank
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bank
            always_ff @(posedge mclk_in)
            begin
                if (srst_in)
                begin
                    bst_r[g]  <= SGR_IDLE;
                    row_r[g]  <= '0;
                    wpb_r[g]  <= 1'b0;
                    ap_r[g]   <= 1'b0;
                    tcnt_r[g] <= '0;
                end
                else
                begin
                    if (tcnt_r[g] != '0)
                        tcnt_r[g] <= tcnt_r[g] - 1'b1;
                    unique case (bst_r[g])
                        SGR_IDLE:
                            if (cmd == SGR_ACT && bk == 1'(g))
                            begin
                                bst_r[g]  <= SGR_ACTIVE;
                                row_r[g]  <= addr_in[ROWW-1:0];
                                wpb_r[g]  <= special_function_select_in;
                                tcnt_r[g] <= 8'(T_RAS_CYC);
                            end
                        SGR_ACTIVE:
                            if (ap_r[g] && tcnt_r[g] <= 8'd1)
                            begin
                                bst_r[g]  <= SGR_PRECH;
                                ap_r[g]   <= 1'b0;
                                tcnt_r[g] <= 8'(T_RP_CYC);
                            end
                            else if ((cmd == SGR_RD || cmd == SGR_WR)
                                     && bk == 1'(g) && addr_in[AP_BIT])
                                ap_r[g] <= 1'b1;
                            else if ((cmd == SGR_PRE && bk == 1'(g))
                                     || cmd == SGR_PALL)
                            begin
                                bst_r[g]  <= SGR_PRECH;
                                tcnt_r[g] <= 8'(T_RP_CYC);
                            end
                        SGR_PRECH:
                            if (tcnt_r[g] <= 8'd1)
                            begin
                                bst_r[g] <= SGR_IDLE;
                                wpb_r[g] <= 1'b0;
                            end
                        default: bst_r[g] <= SGR_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // refresh cycle lockout, self refresh and row counter
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            busy_r    <= '0;
            sref_r    <= 1'b0;
            sr_tmr_r  <= '0;
            ref_row_r <= '0;
            ref_r     <= 1'b0;
        end
        else
        begin
            ref_r <= 1'b0;
            if (busy_r != '0)
                busy_r <= busy_r - 1'b1;
            if (cmd == SGR_AREF && clk_en_r && idle_all)
            begin
                ref_r     <= 1'b1;
                ref_row_r <= ref_row_r + 1'b1;
                busy_r    <= 8'(T_RC_CYC - 1);
            end
            else if (cmd == SGR_SREF && idle_all)
            begin
                sref_r   <= 1'b1;
                sr_tmr_r <= '0;
            end
            else if (sref_r)
            begin
                // only the gate is watched while refreshing alone
                if (cke_in)
                begin
                    sref_r <= 1'b0;
                    busy_r <= 8'(T_RC_CYC);
                end
                else if (sr_tmr_r == 16'(SR_INTERVAL - 1))
                begin
                    sr_tmr_r  <= '0;
                    ref_r     <= 1'b1;
                    ref_row_r <= ref_row_r + 1'b1;
                end
                else
                    sr_tmr_r <= sr_tmr_r + 1'b1;
            end
        end
    end

    // special register loads from the data pins
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            color_r <= COLOR_RST;
            mask_r  <= MASK_RST;
        end
        else if (cmd == SGR_SLOAD)
        begin
            if (addr_in[SEL_COLOR])
                color_r <= dq_in;
            if (addr_in[SEL_MASK])
                mask_r <= dq_in;
        end
    end

    // write data, bit selects and block column selects
    generate
        for (g = 0; g < DW; g++)
        begin : g_bit
            // byte masks and per-bit mask
            assign bitsel[g] = !byte_mask_in[g/8]
                               && (!wpb_r[bk] || mask_r[g]);
        end
        for (g = 0; g < BLK_COLS*MASKW; g++)
        begin : g_col
            // lane g/8 column g%8 chosen by pin g
            assign colsel[g] = dq_in[g] && !byte_mask_in[g/8];
        end
    endgenerate

    assign wq_valid = cmd == SGR_WR && bst_r[bk] == SGR_ACTIVE;
    assign wq_data  = {special_function_select_in, bk, row_r[bk],
                       special_function_select_in
                           ? {addr_in[COLW-1:BLK_LSB], 3'h0}
                           : addr_in[COLW-1:0],
                       special_function_select_in ? color_r : dq_in,
                       bitsel, colsel};

    sgr_fifo #(
        .WIDTH (WQW),
        .DEPTH (FIFO_DEPTH)
    ) u_wq (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .in_valid_in   (wq_valid),
        .in_ready_out  (wq_ready),
        .in_data_in    (wq_data),
        .out_valid_out (oq_valid),
        .out_ready_in  (!wr_en_r || wr_ready_in),
        .out_data_out  (oq_data)
    );

    // one array access per entry, block writes never burst
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            wr_en_r   <= 1'b0;
            wr_pack_r <= '0;
        end
        else if (!wr_en_r || wr_ready_in)
        begin
            wr_en_r   <= oq_valid;
            wr_pack_r <= oq_data;
        end
    end

    // status outputs
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            bank_active_out <= '0;
            self_ref_out    <= 1'b0;
            busy_out        <= 1'b0;
            wq_stall_out    <= 1'b0;
            color_out       <= COLOR_RST;
            mask_out        <= MASK_RST;
        end
        else
        begin
            bank_active_out <= {bst_r[1] == SGR_ACTIVE,
                                bst_r[0] == SGR_ACTIVE};
            self_ref_out    <= sref_r;
            busy_out        <= busy_r != '0;
            // ready is not a pin, so a full queue is reported
            wq_stall_out    <= !wq_ready;
            color_out       <= color_r;
            mask_out        <= mask_r;
        end
    end

    assign wr_en_out     = wr_en_r;
    assign {wr_blk_out, wr_bank_out, wr_row_out, wr_col_out,
            wr_data_out, wr_bitsel_out, wr_colsel_out} = wr_pack_r;
    assign ref_out       = ref_r;
    assign ref_row_out   = ref_row_r;

    ref_lock_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) ref_r && !sref_r |-> busy_r != '0)
        else $error("refresh lockout missing");
    wpb_hold_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) bst_r[0] == SGR_ACTIVE
        && $past(bst_r[0]) == SGR_ACTIVE |-> $stable(wpb_r[0]))
        else $error("per-bit flag changed while open");
    wpb_set_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) cmd == SGR_ACT && !bk && bst_r[0] == SGR_IDLE
        |=> wpb_r[0] == $past(special_function_select_in))
        else $error("per-bit flag not taken at activate");
    color_ld_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) cmd == SGR_SLOAD && addr_in[SEL_COLOR]
        |=> color_r == $past(dq_in))
        else $error("color not loaded");
    pall_idle_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) cmd == SGR_PALL |-> ##[1:8] idle_all)
        else $error("precharge all left a bank open");
    sref_hold_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) sref_r && !cke_in |=> sref_r)
        else $error("self refresh left with gate low");
    cke_lat_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) !cke_in |=> cmd == SGR_NOP)
        else $error("command taken while suspended");
    blk_align_a: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        wr_en_r && wr_blk_out |-> wr_col_out[BLK_LSB-1:0] == 3'h0)
        else $error("block write not aligned");
    ap_close_a: assert property (@(posedge mclk_in)
        disable iff (srst_in) ap_r[0] && bst_r[0] == SGR_ACTIVE
        |-> ##[1:12] bst_r[0] != SGR_ACTIVE)
        else $error("auto precharge did not close bank");
endmodule

// *** core/sgr_pkg.sv ***
// constants for the graphics dram command core
package sgr_pkg;
    localparam int DW          = 32;
    localparam int AW          = 11;
    localparam int COLW        = 8;
    localparam int ROWW        = 10;
    localparam int BLK_COLS    = 8;
    localparam int BLK_LSB     = 3;
    localparam int MASKW       = 4;
    // address bit positions
    localparam int AP_BIT      = 9;
    localparam int BANK_BIT    = 10;
    localparam int SEL_COLOR   = 5;
    localparam int SEL_MASK    = 6;
    // timing, clock 20 MHz
    localparam int CLK_NS      = 50;
    localparam int T_RC_NS     = 80;
    localparam int T_RAS_NS    = 60;
    localparam int T_RP_NS     = 30;
    localparam int T_REF_MS    = 32;
    localparam int T_RC_CYC    = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_RAS_CYC   = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SR_INT_NS   = 15600;
    localparam int SR_INT_CYC  = SR_INT_NS / CLK_NS;
    localparam int NUM_ROWS    = 2048;
    localparam int FIFO_DEPTH  = 8;
    localparam logic [DW-1:0] COLOR_RST = 32'h0000_0000;
    localparam logic [DW-1:0] MASK_RST  = 32'hFFFF_FFFF;

    typedef enum logic [3:0] {
        SGR_NOP   = 4'h0,
        SGR_ACT   = 4'h1,
        SGR_RD    = 4'h2,
        SGR_WR    = 4'h3,
        SGR_PRE   = 4'h4,
        SGR_PALL  = 4'h5,
        SGR_AREF  = 4'h6,
        SGR_SREF  = 4'h7,
        SGR_MODE  = 4'h8,
        SGR_SLOAD = 4'h9
    } sgr_cmd_t;

    typedef enum logic [1:0] {
        SGR_IDLE   = 2'b00,
        SGR_ACTIVE = 2'b01,
        SGR_PRECH  = 2'b10
    } sgr_bank_t;
endpackage

// *** core/sgr_fifo.sv ***
// small valid/ready fifo for write transactions
`timescale 1ns/10ps
module sgr_fifo
    import sgr_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             srst_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [PW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rp_r];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_ff @(posedge mclk_in)
    begin
        if (push)
            mem_r[wp_r] <= in_data_in;
    end

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // occupancy never passes depth
    fifo_bound_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cnt_r <= (PW+1)'(DEPTH))
        else $error("fifo overfilled");
endmodule

// *** bench/sgr_array_model.sv ***
// array write port partner: takes writes promptly or slowly, keeps the last
`timescale 1ns/10ps
module sgr_array_model
    import sgr_pkg::*;
(
    // clock
    input  wire logic            mclk_in,
    // write port from the core
    input  wire logic            wr_en_in,
    input  wire logic            wr_blk_in,
    input  wire logic            wr_bank_in,
    input  wire logic [ROWW-1:0] wr_row_in,
    input  wire logic [COLW-1:0] wr_col_in,
    input  wire logic [DW-1:0]   wr_data_in,
    input  wire logic [DW-1:0]   wr_bitsel_in,
    input  wire logic [DW-1:0]   wr_colsel_in,
    output logic                 wr_ready_out,
    // bench control and capture
    input  wire logic            slow_in,
    output int                   count_out,
    output logic                 blk_out,
    output logic                 bank_out,
    output logic [ROWW-1:0]      row_out,
    output logic [COLW-1:0]      col_out,
    output logic [DW-1:0]        data_out,
    output logic [DW-1:0]        bitsel_out,
    output logic [DW-1:0]        colsel_out
);
    initial
    begin
        wr_ready_out = 1'b1;
        count_out    = 0;
    end

    // slow mode stalls every other cycle so held requests get exercised
    always @(posedge mclk_in)
    begin
        wr_ready_out <= slow_in ? ~wr_ready_out : 1'b1;
        if (wr_en_in === 1'b1 && wr_ready_out === 1'b1)
        begin
            count_out  <= count_out + 1; // one access per write
            blk_out    <= wr_blk_in;
            bank_out   <= wr_bank_in;
            row_out    <= wr_row_in;
            col_out    <= wr_col_in;
            data_out   <= wr_data_in;
            bitsel_out <= wr_bitsel_in;
            colsel_out <= wr_colsel_in;
        end
    end
endmodule

// *** bench/test_sgr_core.sv ***
// self-checking bench for the graphics dram command core
`timescale 1ns/10ps
module test_sgr_core
    import sgr_pkg::*;
;
    logic             mclk_in, srst_in, cke_in, sel_n_in;
    logic             row_n_in, col_n_in, wr_n_in;
    logic             special_function_select_in, slow;
    logic [AW-1:0]    addr_in;
    logic [MASKW-1:0] byte_mask_in;
    logic [DW-1:0]    dq_in, m_data, m_bitsel, m_colsel;
    logic [DW-1:0]    wr_data_out, wr_bitsel_out, wr_colsel_out;
    logic [DW-1:0]    color_out, mask_out;
    logic [COLW-1:0]  wr_col_out, m_col;
    logic [ROWW:0]    ref_row_out;
    logic [1:0]       bank_active_out;
    logic             wr_en_out, wr_blk_out, wr_ready_in, ref_out, m_blk;
    logic             wr_bank_out, m_bank;
    logic [ROWW-1:0]  wr_row_out, m_row;
    logic             self_ref_out, busy_out, wq_stall_out;
    int               bad_count, checked, m_count, refs, busy_seen;
    int               exp_row;
    localparam logic [DW-1:0] COLOR = 32'hC3E1_0FA3;
    localparam logic [DW-1:0] MASK  = 32'h7EB7_FD76;

    sgr_core #(.SR_INTERVAL(4)) DUT (
        .mclk_in(mclk_in), .srst_in(srst_in), .cke_in(cke_in),
        .sel_n_in(sel_n_in), .row_n_in(row_n_in), .col_n_in(col_n_in),
        .wr_n_in(wr_n_in),
        .special_function_select_in(special_function_select_in),
        .addr_in(addr_in), .byte_mask_in(byte_mask_in), .dq_in(dq_in),
        .wr_en_out(wr_en_out), .wr_blk_out(wr_blk_out),
        .wr_bank_out(wr_bank_out), .wr_row_out(wr_row_out),
        .wr_col_out(wr_col_out), .wr_data_out(wr_data_out),
        .wr_bitsel_out(wr_bitsel_out), .wr_colsel_out(wr_colsel_out),
        .wr_ready_in(wr_ready_in), .ref_out(ref_out),
        .ref_row_out(ref_row_out), .bank_active_out(bank_active_out),
        .self_ref_out(self_ref_out), .busy_out(busy_out),
        .wq_stall_out(wq_stall_out), .color_out(color_out),
        .mask_out(mask_out));

    sgr_array_model PARTNER (
        .mclk_in(mclk_in), .wr_en_in(wr_en_out), .wr_blk_in(wr_blk_out),
        .wr_bank_in(wr_bank_out), .wr_row_in(wr_row_out),
        .wr_col_in(wr_col_out), .wr_data_in(wr_data_out),
        .wr_bitsel_in(wr_bitsel_out), .wr_colsel_in(wr_colsel_out),
        .wr_ready_out(wr_ready_in), .slow_in(slow), .count_out(m_count),
        .blk_out(m_blk), .col_out(m_col), .data_out(m_data),
        .bitsel_out(m_bitsel), .colsel_out(m_colsel),
        .bank_out(m_bank), .row_out(m_row));

    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in)
    begin
        if (ref_out === 1'b1)
            refs <= refs + 1;
        if (busy_out === 1'b1)
            busy_seen <= 1;
    end

    task automatic check(input logic [DW-1:0] got, exp, input string what);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // rcw = row, column, write strobes (active low); chip select low
    task automatic issue(input logic cke, input logic [2:0] rcw,
                         input logic special_function_select, input logic [AW-1:0] a,
                         input logic [DW-1:0] d, input logic [3:0] bm);
        @(negedge mclk_in);
        {cke_in, sel_n_in, row_n_in, col_n_in, wr_n_in} = {cke, 1'b0, rcw};
        special_function_select_in = special_function_select;
        addr_in      = a;
        dq_in        = d;
        byte_mask_in = bm;
        @(negedge mclk_in);
        {sel_n_in, row_n_in, col_n_in, wr_n_in} = 4'hF;
        special_function_select_in = 1'b0;
        byte_mask_in = 4'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    task automatic wait_bank(input logic [1:0] exp);
        int i;
        for (i = 0; i < 30 && bank_active_out !== exp; i++)
            @(negedge mclk_in);
        check(32'(bank_active_out), 32'(exp), "bank state");
        if (bank_active_out !== exp)
            test_done();
    endtask

    task automatic wait_write(input int n);
        int i;
        for (i = 0; i < 30 && m_count < n; i++)
            @(negedge mclk_in);
        check(32'(m_count >= n), 32'h1, "write reached array");
        if (m_count < n)
            test_done();
    endtask

    task automatic t_sload();
        check(color_out, 32'h0, "color after reset");
        check(mask_out, 32'hFFFF_FFFF, "mask after reset");
        check(32'(bank_active_out), 32'h0, "banks after reset");
        issue(1'b1, 3'b000, 1'b1, 11'h020, COLOR, 4'h0);
        idle(1);
        check(color_out, COLOR, "color load");
        check(mask_out, 32'hFFFF_FFFF, "mask kept");
        issue(1'b1, 3'b000, 1'b1, 11'h040, MASK, 4'h0);
        idle(1);
        check(mask_out, MASK, "mask load");
        issue(1'b1, 3'b000, 1'b0, 11'h060, 32'h0, 4'h0);
        idle(1);
        check(color_out, COLOR, "mode load leaves color");
    endtask

    // per-bit write with auto precharge; byte lane 0 masked
    task automatic t_perbit();
        issue(1'b1, 3'b011, 1'b1, 11'h0A5, 32'h0, 4'h0);
        idle(3);
        issue(1'b1, 3'b100, 1'b0, 11'h212, 32'hFFFF_0000, 4'h1);
        wait_write(1);
        check(32'(m_blk), 32'h0, "plain write");
        check(32'(m_col), 32'h12, "write column");
        check(32'(m_row), 32'h0A5, "write row");
        check(32'(m_bank), 32'h0, "write bank");
        check(m_data, 32'hFFFF_0000, "write data");
        check(m_bitsel, MASK & 32'hFFFF_FF00, "bit select");
        wait_bank(2'b00);
    endtask

    // block write on bank 1, per-bit off, slow array, lane 0 masked
    task automatic t_block();
        slow = 1'b1;
        issue(1'b1, 3'b011, 1'b0, 11'h400, 32'h0, 4'h0);
        idle(3);
        check(32'(bank_active_out), 32'h2, "bank 1 open");
        issue(1'b1, 3'b100, 1'b1, 11'h40D, 32'h7777_BBDE, 4'h1);
        wait_write(2);
        idle(6);
        check(32'(m_count), 32'd2, "one block access");
        check(32'(m_blk), 32'h1, "block flag");
        check(32'(m_col), 32'h08, "aligned column");
        check(m_data, COLOR, "block data");
        check(m_colsel, 32'h7777_BB00, "column select");
        check(m_bitsel, 32'hFFFF_FF00, "block bit select");
        check(32'(m_bank), 32'h1, "block bank");
        check(32'(wq_stall_out), 32'h0, "queue not full");
        check(32'(bank_active_out), 32'h2, "bank stays open");
        slow = 1'b0;
    endtask

    task automatic t_precharge();
        issue(1'b1, 3'b011, 1'b0, 11'h000, 32'h0, 4'h0);
        idle(4);
        issue(1'b1, 3'b010, 1'b0, 11'h400, 32'h0, 4'h0);
        wait_bank(2'b01);
        issue(1'b1, 3'b010, 1'b0, 11'h200, 32'h0, 4'h0);
        wait_bank(2'b00);
    endtask

    // refresh, then a refused activate inside the lockout
    task automatic t_refresh();
        int r0;
        r0 = refs;
        busy_seen = 0;
        // activate follows one cycle after refresh, inside the lockout
        @(negedge mclk_in);
        {sel_n_in, row_n_in, col_n_in, wr_n_in} = 4'h1;
        @(negedge mclk_in);
        {row_n_in, col_n_in, wr_n_in} = 3'h3;
        @(negedge mclk_in);
        {sel_n_in, row_n_in, col_n_in, wr_n_in} = 4'hF;
        exp_row++;
        idle(4);
        check(32'(refs - r0), 32'd1, "one refresh");
        check(32'(ref_row_out), 32'(exp_row), "row counter");
        check(32'(busy_seen), 32'd1, "lockout shown");
        check(32'(bank_active_out), 32'h0, "lockout refusal");
    endtask

    task automatic t_selfref();
        int r0;
        issue(1'b0, 3'b001, 1'b0, 11'h000, 32'h0, 4'h0);
        idle(2);
        r0 = refs;
        check(32'(self_ref_out), 32'h1, "self refresh in");
        issue(1'b0, 3'b011, 1'b0, 11'h000, 32'h0, 4'h0);
        idle(20);
        check(32'(self_ref_out), 32'h1, "stays in");
        check(32'(refs > r0), 32'h1, "internal refresh");
        check(32'(bank_active_out), 32'h0, "inputs ignored");
        cke_in = 1'b1;
        idle(6);
        check(32'(self_ref_out), 32'h0, "self refresh out");
    endtask

    task automatic t_suspend();
        issue(1'b0, 3'b111, 1'b0, 11'h000, 32'h0, 4'h0);
        issue(1'b1, 3'b011, 1'b0, 11'h000, 32'h0, 4'h0);
        idle(3);
        check(32'(bank_active_out), 32'h0, "suspended cmd");
        issue(1'b1, 3'b011, 1'b0, 11'h000, 32'h0, 4'h0);
        idle(3);
        check(32'(bank_active_out), 32'h1, "resumed cmd");
    endtask

    initial
    begin
        {srst_in, cke_in, sel_n_in, row_n_in, col_n_in, wr_n_in} = 6'h3F;
        special_function_select_in = 1'b0;
        addr_in      = '0;
        dq_in        = '0;
        byte_mask_in = '0;
        slow         = 1'b0;
        bad_count    = 0;
        checked      = 0;
        refs         = 0;
        busy_seen    = 0;
        exp_row      = 0;
        idle(8);
        srst_in = 1'b0;
        idle(1);
        t_sload();
        t_perbit();
        t_block();
        t_precharge();
        t_refresh();
        t_selfref();
        t_suspend();
        test_done();
    end
endmodule
